// >>> rtl/fwoc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module fwoc_ctrl
  import fwoc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // program/erase controller
  output logic opStart,
  output logic opResume,
  output logic opSuspend,
  output logic [1:0] opKind,
  output logic [23:0] opAddr,
  output logic [31:0] opData0,
  output logic [31:0] opData1,
  output logic [11:0] opSectors,
  input wire logic opDone,
  input wire logic opFail,
  // bank access path
  input wire logic bankRdReq,
  input wire logic [31:0] arrayRdData,
  output logic bankRdValid,
  output logic [31:0] bankRdData,
  input wire logic bankWrReq,
  output logic bankWrGo,
  // status
  output logic bankBusy,
  output logic regLock
);

  // ==========================================================
  // state
  fwoc_state_t st;
  fwoc_state_t next_st;

  logic [31:0] wrWord;
  logic [15:0] ctrlWord;
  logic chkAccept;
  logic chkResume;
  logic chkFault;
  fwoc_op_t chkOp;

  function automatic logic [31:0] mergeW(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================
  // control word view
  always_comb begin
    ctrlWord = CTRL_RESET;
    ctrlWord[START_BIT] = st.wStart;
    ctrlWord[SUSPEND_BIT_BIT] = st.suspend_bit;
    ctrlWord[WORD_BIT] = st.wordSel;
    ctrlWord[DWORD_BIT] = st.dwordSel;
    ctrlWord[ERASE_BIT] = st.eraseSel;
    ctrlWord[PROT_BIT] = st.protSel;
    ctrlWord[LEGACY_BIT] = st.legacy;
  end

  assign wrWord = mergeW({16'h0000, ctrlWord}, st.wData, st.wStrb);

  // launch decision on the select bits as they stand after this write
  fwoc_launch_check u_check (
    .sel({wrWord[WORD_BIT], wrWord[DWORD_BIT], wrWord[ERASE_BIT], wrWord[PROT_BIT]}),
    .errFlag(st.errFlag),
    .suspended(st.suspended),
    .suspOp(st.runOp),
    .addr(st.addr),
    .sectors(st.sectors),
    .accept(chkAccept),
    .isResume(chkResume),
    .seqFault(chkFault),
    .op(chkOp)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] m;
    logic doWrite;
    m = 32'h00000000;
    doWrite = 1'b0;
    next_st = st;
    next_st.cmdStart = 1'b0;
    next_st.cmdResume = 1'b0;
    next_st.cmdSuspend = 1'b0;

    // bank path: trap reads and drop writes while a write runs
    next_st.bankRdValid = bankRdReq;
    next_st.bankRdData = st.busy ? TRAP_WORD : arrayRdData;
    next_st.bankWrGo = bankWrReq & ~st.busy;

    // ---------------- read channel
    if (arvalid && st.arRdy) begin
      next_st.arRdy = 1'b0;
      next_st.rValid = 1'b1;
      next_st.rResp = RESP_OKAY;
      next_st.rData = 32'h00000000;
      case (araddr)
        CTRL_OFS: next_st.rData = {16'h0000, ctrlWord};
        STAT_OFS: begin
          // always readable so software can poll for the end of a write
          next_st.rData[BUSY_BIT] = st.busy;
          next_st.rData[LOCK_BIT] = st.lock;
          next_st.rData[SUSPENDED_BIT] = st.suspended;
        end
        ADDR_OFS: next_st.rData = {8'h00, st.addr};
        DATA0_OFS: next_st.rData = st.data0;
        DATA1_OFS: next_st.rData = st.data1;
        SECT_OFS: next_st.rData = {20'h00000, st.sectors};
        ERR_OFS: begin
          next_st.rData[ERR_BIT] = st.errFlag;
          next_st.rData[SEQ_BIT] = st.seqErr;
        end
        default: next_st.rResp = RESP_SLVERR;
      endcase
      if (st.lock && araddr != STAT_OFS && next_st.rResp == RESP_OKAY) begin
        next_st.rData = TRAP_WORD;
      end
    end else if (st.rValid && rready) begin
      next_st.rValid = 1'b0;
      next_st.arRdy = 1'b1;
    end

    // ---------------- write channels, taken in either order
    if (awvalid && st.awRdy) begin
      next_st.awRdy = 1'b0;
      next_st.wAddr = awaddr;
    end
    if (wvalid && st.wRdy) begin
      next_st.wRdy = 1'b0;
      next_st.wData = wdata;
      next_st.wStrb = wstrb;
    end
    if (st.bValid && bready) begin
      next_st.bValid = 1'b0;
      next_st.awRdy = 1'b1;
      next_st.wRdy = 1'b1;
    end
    if (!st.awRdy && !st.wRdy && !st.bValid) begin
      doWrite = 1'b1;
      next_st.bValid = 1'b1;
      next_st.bResp = RESP_OKAY;
    end

    if (doWrite) begin
      case (st.wAddr)
        CTRL_OFS: begin
          if (st.lock) begin
            // suspend is the one control write honoured while locked
            if (wrWord[SUSPEND_BIT_BIT] && st.busy && st.runOp != OP_PROT) begin
              next_st.suspend_bit = 1'b1;
              next_st.suspended = 1'b1;
              next_st.wStart = 1'b0;
              next_st.busy = 1'b0;
              next_st.lock = 1'b0;
              next_st.cmdSuspend = 1'b1;
            end
          end else begin
            next_st.wordSel = wrWord[WORD_BIT];
            next_st.dwordSel = wrWord[DWORD_BIT];
            next_st.eraseSel = wrWord[ERASE_BIT];
            next_st.protSel = wrWord[PROT_BIT];
            next_st.legacy = wrWord[LEGACY_BIT];
            // a zero on write-start is simply not acted on
            if (wrWord[START_BIT]) begin
              if (chkAccept) begin
                next_st.wStart = 1'b1;
                next_st.busy = 1'b1;
                next_st.lock = 1'b1;
                if (chkResume) begin
                  next_st.suspend_bit = 1'b0;
                  next_st.suspended = 1'b0;
                  next_st.cmdResume = 1'b1;
                end else begin
                  next_st.runOp = chkOp;
                  next_st.cmdStart = 1'b1;
                end
              end
            end
          end
        end
        ADDR_OFS: begin
          if (!st.lock) begin
            m = mergeW({8'h00, st.addr}, st.wData, st.wStrb);
            next_st.addr = m[23:0];
          end
        end
        DATA0_OFS: begin
          if (!st.lock) begin
            next_st.data0 = mergeW(st.data0, st.wData, st.wStrb);
          end
        end
        DATA1_OFS: begin
          if (!st.lock) begin
            next_st.data1 = mergeW(st.data1, st.wData, st.wStrb);
          end
        end
        SECT_OFS: begin
          if (!st.lock) begin
            m = mergeW({20'h00000, st.sectors}, st.wData, st.wStrb);
            next_st.sectors = m[11:0];
          end
        end
        ERR_OFS: begin
          // write one to clear
          if (!st.lock && st.wStrb[0]) begin
            if (st.wData[ERR_BIT]) begin
              next_st.errFlag = 1'b0;
            end
            if (st.wData[SEQ_BIT]) begin
              next_st.seqErr = 1'b0;
            end
          end
        end
        STAT_OFS: begin
          next_st.bResp = RESP_OKAY;
        end
        default: next_st.bResp = RESP_SLVERR;
      endcase
    end

    // ---------------- hardware events come last so a set beats a clear
    if (doWrite && st.wAddr == CTRL_OFS && !st.lock && wrWord[START_BIT] && chkFault) begin
      next_st.seqErr = 1'b1;
      next_st.errFlag = 1'b1;
    end
    if (st.busy && opDone) begin
      next_st.wStart = 1'b0;
      next_st.busy = 1'b0;
      next_st.lock = 1'b0;
      case (st.runOp)
        OP_WORD: next_st.wordSel = 1'b0;
        OP_DWORD: next_st.dwordSel = 1'b0;
        OP_ERASE: next_st.eraseSel = 1'b0;
        default: next_st.protSel = 1'b0;
      endcase
    end
    if (st.busy && opFail) begin
      next_st.errFlag = 1'b1;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.awRdy <= 1'b1;
      st.wRdy <= 1'b1;
      st.arRdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign awready = st.awRdy;
  assign wready = st.wRdy;
  assign bvalid = st.bValid;
  assign bresp = st.bResp;
  assign arready = st.arRdy;
  assign rvalid = st.rValid;
  assign rdata = st.rData;
  assign rresp = st.rResp;
  assign opStart = st.cmdStart;
  assign opResume = st.cmdResume;
  assign opSuspend = st.cmdSuspend;
  assign opKind = st.runOp;
  assign opAddr = st.addr;
  assign opData0 = st.data0;
  assign opData1 = st.data1;
  assign opSectors = st.sectors;
  assign bankRdValid = st.bankRdValid;
  assign bankRdData = st.bankRdData;
  assign bankWrGo = st.bankWrGo;
  assign bankBusy = st.busy;
  assign regLock = st.lock;

endmodule // fwoc_ctrl
`default_nettype wire

// >>> rtl/fwoc_pkg.sv
package fwoc_pkg;

  // ==========================================================
  // register map (byte offsets)
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] ADDR_OFS = 8'h08;
  localparam logic [7:0] DATA0_OFS = 8'h0C;
  localparam logic [7:0] DATA1_OFS = 8'h10;
  localparam logic [7:0] SECT_OFS = 8'h14;
  localparam logic [7:0] ERR_OFS = 8'h18;

  // ==========================================================
  // control word fields
  localparam int START_BIT = 15;
  localparam int SUSPEND_BIT_BIT = 14;
  localparam int WORD_BIT = 13;
  localparam int DWORD_BIT = 12;
  localparam int ERASE_BIT = 11;
  localparam int PROT_BIT = 8;
  localparam int LEGACY_BIT = 7;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // status and error fields
  localparam int BUSY_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int SUSPENDED_BIT = 2;
  localparam int ERR_BIT = 0;
  localparam int SEQ_BIT = 1;

  // ==========================================================
  // values
  localparam logic [31:0] TRAP_WORD = 32'h0000009B;
  localparam logic [23:0] PROT_LO = 24'h0EDFB0;
  localparam logic [23:0] PROT_HI = 24'h0EDFBF;
  localparam logic [23:0] TEST_LO = 24'h0F0000;
  localparam logic [23:0] TEST_HI = 24'h0F3FFF;
  localparam int DWORD_ALIGN_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {OP_WORD, OP_DWORD, OP_ERASE, OP_PROT} fwoc_op_t;

  typedef struct packed {
    logic awRdy;
    logic wRdy;
    logic arRdy;
    logic bValid;
    logic rValid;
    logic [1:0] bResp;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic [7:0] wAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wStart;
    logic suspend_bit;
    logic wordSel;
    logic dwordSel;
    logic eraseSel;
    logic protSel;
    logic legacy;
    logic busy;
    logic lock;
    logic suspended;
    fwoc_op_t runOp;
    logic errFlag;
    logic seqErr;
    logic [23:0] addr;
    logic [31:0] data0;
    logic [31:0] data1;
    logic [11:0] sectors;
    logic cmdStart;
    logic cmdResume;
    logic cmdSuspend;
    logic bankRdValid;
    logic [31:0] bankRdData;
    logic bankWrGo;
  } fwoc_state_t;

endpackage

// >>> rtl/fwoc_launch_check.sv
`timescale 1ns/1ps
`default_nettype none
module fwoc_launch_check
  import fwoc_pkg::*;
(
  // request
  input wire logic [3:0] sel,
  input wire logic errFlag,
  input wire logic suspended,
  input wire fwoc_op_t suspOp,
  input wire logic [23:0] addr,
  input wire logic [11:0] sectors,
  // verdict
  output logic accept,
  output logic isResume,
  output logic seqFault,
  output fwoc_op_t op
);

  logic testHit;

  assign testHit = (addr >= TEST_LO) && (addr <= TEST_HI);

  always_comb begin
    accept = 1'b0;
    isResume = 1'b0;
    seqFault = 1'b0;
    case (sel)
      4'h8: op = OP_WORD;
      4'h4: op = OP_DWORD;
      4'h2: op = OP_ERASE;
      default: op = OP_PROT;
    endcase
    if (errFlag) begin
      accept = 1'b0;
    end else if (suspended) begin
      // only the matching resume passes; anything else is dropped quietly
      if ($onehot(sel) && op == suspOp) begin
        accept = 1'b1;
        isResume = 1'b1;
      end
    end else if (!$onehot(sel)) begin
      seqFault = 1'b1;
    end else begin
      case (op)
        OP_WORD: seqFault = testHit;
        OP_DWORD: seqFault = testHit | addr[DWORD_ALIGN_BIT];
        OP_ERASE: seqFault = (sectors == 12'h000);
        default: seqFault = (addr < PROT_LO) || (addr > PROT_HI);
      endcase
      accept = ~seqFault;
    end
  end

endmodule // fwoc_launch_check
`default_nettype wire

// >>> sim/fwoc_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// controller-side checks
module fwoc_ctrl_checker
  import fwoc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controller
  input wire logic opStart,
  input wire logic opResume,
  input wire logic opSuspend,
  input wire logic opDone,
  // bank path
  input wire logic bankRdReq,
  input wire logic [31:0] arrayRdData,
  input wire logic bankRdValid,
  input wire logic [31:0] bankRdData,
  input wire logic bankWrReq,
  input wire logic bankWrGo,
  // status
  input wire logic bankBusy,
  input wire logic regLock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_start_sets_busy: assert property (opStart |-> bankBusy && regLock)
    else $error("start without busy and lock");
  a_busy_has_cause: assert property ($rose(bankBusy) |-> opStart || opResume)
    else $error("busy rose without launch");
  a_done_ends_op: assert property (bankBusy && opDone |=> !bankBusy && !regLock)
    else $error("busy held after done");
  a_suspend_frees_bank: assert property (opSuspend |-> !bankBusy && !regLock)
    else $error("bank still busy in suspend");
  a_resume_rebusy: assert property (opResume |-> bankBusy && regLock)
    else $error("resume without busy");
  a_busy_trap_read: assert property (bankRdReq && bankBusy |=> bankRdValid && bankRdData == TRAP_WORD)
    else $error("busy read not trapped");
  a_idle_read_pass: assert property (bankRdReq && !bankBusy |=> bankRdData == $past(arrayRdData))
    else $error("idle read data wrong");
  a_busy_drop_write: assert property (bankWrReq && bankBusy |=> !bankWrGo)
    else $error("bank write passed while busy");
  a_idle_write_go: assert property (bankWrReq && !bankBusy |=> bankWrGo)
    else $error("idle bank write dropped");
  c_start: cover property (opStart);
  c_suspend: cover property (opSuspend);
  c_resume: cover property (opResume);
  c_done: cover property (bankBusy && opDone);
endmodule // fwoc_ctrl_checker
bind fwoc_ctrl fwoc_ctrl_checker i_fwoc_ctrl_checker (.clk(clk), .rst_n(rst_n),
  .opStart(opStart), .opResume(opResume), .opSuspend(opSuspend), .opDone(opDone),
  .bankRdReq(bankRdReq), .arrayRdData(arrayRdData), .bankRdValid(bankRdValid),
  .bankRdData(bankRdData), .bankWrReq(bankWrReq), .bankWrGo(bankWrGo),
  .bankBusy(bankBusy), .regLock(regLock));
`default_nettype wire

// >>> sim/fwoc_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fwoc_ctrl_bench
  import fwoc_pkg::*;
;
  typedef struct packed {logic [23:0] a; logic [11:0] s; logic [15:0] c; logic [1:0] e;} fwoc_row_t;
  localparam logic [7:0] NOMAP = 8'h1C;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, opDone, opFail;
  logic awready, wready, bvalid, arready, rvalid, opStart, opResume, opSuspend;
  logic bankRdReq, bankWrReq, bankRdValid, bankWrGo, bankBusy, regLock;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, opKind;
  logic [23:0] opAddr;
  logic [11:0] opSectors;
  logic [31:0] wdata, rdata, opData0, opData1, arrayRdData, bankRdData;
  logic [15:0] cyc = 16'h0000;
  int failures = 0;
  int samples_checked = 0;
  fwoc_row_t rows [13];

  fwoc_ctrl i_fwoc_ctrl (.clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .opStart(opStart), .opResume(opResume), .opSuspend(opSuspend), .opKind(opKind),
    .opAddr(opAddr), .opData0(opData0), .opData1(opData1), .opSectors(opSectors),
    .opDone(opDone), .opFail(opFail), .bankRdReq(bankRdReq), .arrayRdData(arrayRdData),
    .bankRdValid(bankRdValid), .bankRdData(bankRdData), .bankWrReq(bankWrReq),
    .bankWrGo(bankWrGo), .bankBusy(bankBusy), .regLock(regLock));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // bank traffic runs all the time so both busy and idle windows see it
  always @(posedge clk) begin
    cyc <= cyc + 16'h0001;
    bankRdReq <= cyc[0];
    bankWrReq <= cyc[1];
    arrayRdData <= {cyc, ~cyc};
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ======================================================
  // bus tasks: responses are sampled at the falling edge, where the
  // registered outputs already hold the value of the preceding rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    for (n = 0; n < 40 && !tb; n++) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      if (tb) chk({30'h0, bresp}, {30'h0, a == NOMAP ? RESP_SLVERR : RESP_OKAY});
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    chk({31'h0, tb}, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic ta, tb;
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tb = 1'b0;
    for (n = 0; n < 40 && !tb; n++) begin
      @(negedge clk);
      ta = arvalid && arready;
      tb = rvalid;
      if (tb) chk(rdata & m, e);
      if (tb) chk({30'h0, rresp}, {30'h0, a == NOMAP ? RESP_SLVERR : RESP_OKAY});
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tb) rready <= 1'b0;
    end
    chk({31'h0, tb}, 32'h1);
  endtask

  task automatic pulse_done(input logic f);
    @(posedge clk);
    opDone <= 1'b1;
    opFail <= f;
    @(posedge clk);
    opDone <= 1'b0;
    opFail <= 1'b0;
  endtask

  function automatic logic [1:0] kind(input logic [15:0] c);
    return c[WORD_BIT] ? 2'h0 : c[DWORD_BIT] ? 2'h1 : c[ERASE_BIT] ? 2'h2 : 2'h3;
  endfunction

  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end

  // ======================================================
  // main sequence
  initial begin
    rst_n <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, opDone, opFail} <= 7'h00;
    {bankRdReq, bankWrReq} <= 2'h0;
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h0;
    wstrb <= 4'hF;
    arrayRdData <= 32'h0;
    rows[0] = '{24'h000100, 12'h000, 16'hA000, 2'h0};
    rows[1] = '{24'h0F0000, 12'h000, 16'hA000, 2'h3};
    rows[2] = '{24'h0F3FFF, 12'h000, 16'hA000, 2'h3};
    rows[3] = '{24'h000104, 12'h000, 16'h9000, 2'h3};
    rows[4] = '{24'h000108, 12'h000, 16'h9000, 2'h0};
    rows[5] = '{24'h000000, 12'h000, 16'h8800, 2'h3};
    rows[6] = '{24'h000000, 12'h801, 16'h8800, 2'h0};
    rows[7] = '{24'h0EDFAF, 12'h000, 16'h8100, 2'h3};
    rows[8] = '{24'h0EDFB0, 12'h000, 16'h8100, 2'h0};
    rows[9] = '{24'h0EDFBF, 12'h000, 16'h8100, 2'h0};
    rows[10] = '{24'h0EDFC0, 12'h000, 16'h8100, 2'h3};
    rows[11] = '{24'h000200, 12'h000, 16'hB000, 2'h3};
    rows[12] = '{24'h000200, 12'h000, 16'hA080, 2'h0};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(CTRL_OFS, ALL, {16'h0, CTRL_RESET});
    rd(STAT_OFS, ALL, 32'h0);
    wr(NOMAP, 32'h1);
    rd(NOMAP, ALL, 32'h0);
    wr(STAT_OFS, 32'h7);
    rd(STAT_OFS, ALL, 32'h0);
    wr(DATA0_OFS, 32'h12345678);
    wr(DATA1_OFS, 32'h9ABCDEF0);
    rd(DATA0_OFS, ALL, 32'h12345678);
    for (int i = 0; i < 13; i++) begin
      wr(ADDR_OFS, {8'h00, rows[i].a});
      wr(SECT_OFS, {20'h0, rows[i].s});
      wr(CTRL_OFS, {16'h0, rows[i].c & 16'h7FFF});
      wr(CTRL_OFS, {16'h0, rows[i].c});
      rd(ERR_OFS, ALL, rows[i].e != 2'h0 ? {30'h0, rows[i].e} : TRAP_WORD);
      if (rows[i].e != 2'h0) begin
        wr(ERR_OFS, 32'h3);
      end else begin
        chk({30'h0, opKind}, {30'h0, kind(rows[i].c)});
        chk({8'h0, opAddr}, {8'h0, rows[i].a});
        chk({20'h0, opSectors}, {20'h0, rows[i].s});
        chk(opData0 ^ opData1, 32'h12345678 ^ 32'h9ABCDEF0);
        wr(CTRL_OFS, 32'h0);
        rd(STAT_OFS, ALL, 32'h3);
        pulse_done(1'b0);
        rd(STAT_OFS, ALL, 32'h0);
        rd(CTRL_OFS, 32'hF900, 32'h0);
      end
    end
    wr(SECT_OFS, 32'h5);
    wr(CTRL_OFS, 32'h0800);
    wr(CTRL_OFS, 32'h8800);
    wr(CTRL_OFS, 32'h4000);
    rd(STAT_OFS, ALL, 32'h4);
    wr(CTRL_OFS, 32'hA000);
    rd(STAT_OFS, ALL, 32'h4);
    wr(CTRL_OFS, 32'h8800);
    rd(STAT_OFS, ALL, 32'h3);
    pulse_done(1'b0);
    rd(STAT_OFS, ALL, 32'h0);
    wr(CTRL_OFS, 32'hA000);
    pulse_done(1'b1);
    rd(ERR_OFS, ALL, 32'h1);
    wr(CTRL_OFS, 32'hA000);
    rd(STAT_OFS, ALL, 32'h0);
    wr(ERR_OFS, 32'h1);
    rd(ERR_OFS, ALL, 32'h0);
    tally_and_finish();
  end
endmodule // fwoc_ctrl_bench
`default_nettype wire
